// file: sponge_cipher_map.vh
// Constants for the sponge authenticated cipher engine.
// Assumes inclusion by the engine, monitor and bench files; definitions only.
`ifndef SPONGE_CIPHER_MAP_VH
`define SPONGE_CIPHER_MAP_VH

// =====================================================================
// Command codes
`define CMD_IDLE 32'h0000_0000
`define CMD_LOAD_KEY 32'h0000_0004
`define CMD_LOAD_NONCE 32'h0000_0005
`define CMD_INIT 32'h0000_0006
`define CMD_ASSOC 32'h0000_0007
`define CMD_ENCRYPT 32'h0000_0008
`define CMD_LAST_ENC 32'h0000_0009
`define CMD_DECRYPT 32'h0000_000A
`define CMD_LAST_DEC 32'h0000_000B
`define CMD_READ_TAG 32'h0000_000C

// =====================================================================
// Status bit positions
`define ST_INIT_BIT 0
`define ST_ASSOC_BIT 1
`define ST_ENC_BIT 2
`define ST_DEC_BIT 3
`define ST_LAST_ENC_BIT 4
`define ST_LAST_DEC_BIT 5
`define ST_RESET 32'h0000_0000

// =====================================================================
// Permutation: 12 rounds start at index 0, 8 rounds at index 4
`define RND_FIRST_A 4'h0
`define RND_FIRST_B 4'h4
`define RND_LAST 4'hB
`define CIPHER_IV 64'h8080_0C08_0000_0000

// =====================================================================
// Data FIFO shape and reset values
`define BLK_WIDTH 128
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define BLK_RESET 128'h0000_0000_0000_0000_0000_0000_0000_0000

`endif

// file: sponge_stream_cipher.v
// Sponge authenticated cipher engine with a persistent 320-bit state,
// plus the four-word input block FIFO it drains.
// Assumes software presents commands as a one-cycle strobe and input
// blocks through the FIFO; one clock, synchronous active-high reset.
//
// How it works
// - Twelve rounds init/final, eight per block, 128-bit rate
// - Session takes 128-bit key and 128-bit nonce
// - Ciphertext matches plaintext length, plus 128-bit tag
// - Decrypt flags failure when tag does not verify
// - Init builds the held 320-bit stream state
// - Init, data and last operations update the held state in place; key, nonce and tag read leave it
// - Associated data absorbs one block, no output
// - Encrypt/decrypt map one block to one block
// - Last-decrypt compares tag, reports pass or fail
// - Command strobe starts work, status shows progress
// - Code zero idles, code four loads key
// - Output blocks and read-tag go to data output
// - Status bits 0..5 show the running operation; key and nonce loads set none
`timescale 1ns/1ps
`include "sponge_cipher_map.vh"

// =====================================================================
// Block FIFO
module block_fifo #(
	parameter WIDTH = 128,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// Fill side
	input wire in_valid,
	output reg in_ready,
	input wire [WIDTH-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // Storage words
	reg [AW-1:0] wr_ptr_q; // Next slot to fill
	reg [AW-1:0] rd_ptr_q; // Next slot to drain
	reg [AW:0] count_q; // Words held
	wire push; // Word accepted this cycle
	wire pop; // Word taken this cycle
	wire [AW:0] count_d; // Next fill level

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = mem_q[rd_ptr_q];
	assign count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// Pointers, level and registered ready so back-pressure is honest
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			in_ready <= 1'b0;
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= in_data;
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			in_ready <= (count_d != DEPTH[AW:0]);
		end
	end
endmodule // block_fifo

// =====================================================================
// Cipher engine
module sponge_stream_cipher (
	// Clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// Command strobe
	input wire cmd_valid,
	input wire [31:0] cmd_code,
	// Input block stream
	input wire din_valid,
	output wire din_ready,
	input wire [127:0] din_data,
	// Results
	output reg [127:0] dout_q,
	output reg [31:0] status_q,
	output reg busy_q,
	output reg done_q,
	output reg tag_ok_q,
	output reg tag_fail_q
);
	// States
	localparam S_IDLE = 2'd0;
	localparam S_DATA = 2'd1;
	localparam S_PERM = 2'd2;
	localparam S_POST = 2'd3;

	reg [1:0] state_q; // Sequencer state
	reg [31:0] op_q; // Command in progress
	reg [319:0] st_q; // Held sponge state, x0 in the top word
	reg [127:0] key_q; // Loaded key
	reg [127:0] nonce_q; // Loaded nonce
	reg [127:0] tag_in_q; // Tag received for checking
	reg [3:0] rnd_q; // Round index
	wire fifo_valid; // Block waiting
	wire [127:0] fifo_data; // Head block
	reg fifo_pop; // Take head block
	wire [127:0] tag_calc; // Tag from final state

	assign tag_calc = st_q[127:0] ^ key_q;

	// Rotate a 64-bit lane right
	function [63:0] ror;
		input [63:0] x;
		input [5:0] n;
		reg [127:0] w;
		begin
			w = {x, x} >> n;
			ror = w[63:0];
		end
	endfunction

	// One permutation round: constant, bitsliced substitution, diffusion
	function [319:0] round;
		input [319:0] s;
		input [3:0] r;
		reg [63:0] x0, x1, x2, x3, x4, t0, t1, t2, t3, t4;
		begin
			x0 = s[319:256];
			x1 = s[255:192];
			x2 = s[191:128] ^ {56'h0, 4'hF - r, r};
			x3 = s[127:64];
			x4 = s[63:0];
			x0 = x0 ^ x4;
			x4 = x4 ^ x3;
			x2 = x2 ^ x1;
			t0 = ~x0 & x1;
			t1 = ~x1 & x2;
			t2 = ~x2 & x3;
			t3 = ~x3 & x4;
			t4 = ~x4 & x0;
			x0 = x0 ^ t1;
			x1 = x1 ^ t2;
			x2 = x2 ^ t3;
			x3 = x3 ^ t4;
			x4 = x4 ^ t0;
			x1 = x1 ^ x0;
			x0 = x0 ^ x4;
			x3 = x3 ^ x2;
			x2 = ~x2;
			x0 = x0 ^ ror(x0, 6'd19) ^ ror(x0, 6'd28);
			x1 = x1 ^ ror(x1, 6'd61) ^ ror(x1, 6'd39);
			x2 = x2 ^ ror(x2, 6'd1) ^ ror(x2, 6'd6);
			x3 = x3 ^ ror(x3, 6'd10) ^ ror(x3, 6'd17);
			x4 = x4 ^ ror(x4, 6'd7) ^ ror(x4, 6'd41);
			round = {x0, x1, x2, x3, x4};
		end
	endfunction

	// Status pattern for a command
	function [31:0] busy_bits;
		input [31:0] c;
		begin
			busy_bits = `ST_RESET;
			case (c)
				`CMD_INIT: busy_bits[`ST_INIT_BIT] = 1'b1;
				`CMD_ASSOC: busy_bits[`ST_ASSOC_BIT] = 1'b1;
				`CMD_ENCRYPT: busy_bits[`ST_ENC_BIT] = 1'b1;
				`CMD_DECRYPT: busy_bits[`ST_DEC_BIT] = 1'b1;
				`CMD_LAST_ENC: busy_bits[`ST_LAST_ENC_BIT] = 1'b1;
				`CMD_LAST_DEC: busy_bits[`ST_LAST_DEC_BIT] = 1'b1;
				default: busy_bits = `ST_RESET;
			endcase
		end
	endfunction

	// Final-block padding and key mix before the closing twelve rounds
	function [319:0] finalize_prep;
		input [319:0] s;
		input [127:0] k;
		begin
			finalize_prep = s ^ {1'b1, 127'h0, k, 64'h0};
		end
	endfunction

	// Input blocks wait here; a stalled engine fills it and drops din_ready
	block_fifo #(
		.WIDTH(`BLK_WIDTH),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) block_fifo_inst (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(din_valid),
		.in_ready(din_ready),
		.in_data(din_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	// Pop whenever the engine waits for its operand
	always @* begin
		fifo_pop = (state_q == S_DATA) & fifo_valid;
	end

	// Command sequencer and sponge datapath
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
			op_q <= `CMD_IDLE;
			st_q <= 320'h0;
			key_q <= `BLK_RESET;
			nonce_q <= `BLK_RESET;
			tag_in_q <= `BLK_RESET;
			rnd_q <= `RND_FIRST_A;
			dout_q <= `BLK_RESET;
			status_q <= `ST_RESET;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			tag_ok_q <= 1'b0;
			tag_fail_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				// Take a command; code zero and unknown codes do nothing
				S_IDLE: begin
					if (cmd_valid) begin
						op_q <= cmd_code;
						status_q <= busy_bits(cmd_code);
						case (cmd_code)
							`CMD_LOAD_KEY, `CMD_LOAD_NONCE, `CMD_ASSOC,
							`CMD_ENCRYPT, `CMD_DECRYPT, `CMD_LAST_DEC: begin
								state_q <= S_DATA;
								busy_q <= 1'b1;
							end
							`CMD_INIT: begin
								st_q <= {`CIPHER_IV, key_q, nonce_q};
								rnd_q <= `RND_FIRST_A;
								state_q <= S_PERM;
								busy_q <= 1'b1;
							end
							`CMD_LAST_ENC: begin
								tag_ok_q <= 1'b0;
								tag_fail_q <= 1'b0;
								st_q <= finalize_prep(st_q, key_q);
								rnd_q <= `RND_FIRST_A;
								state_q <= S_PERM;
								busy_q <= 1'b1;
							end
							`CMD_READ_TAG: begin
								dout_q <= tag_calc;
								done_q <= 1'b1;
							end
							default: begin
								state_q <= S_IDLE;
							end
						endcase
					end
				end
				// Consume the operand block
				S_DATA: begin
					if (fifo_valid) begin
						rnd_q <= `RND_FIRST_B;
						state_q <= S_PERM;
						case (op_q)
							`CMD_LOAD_KEY: begin
								key_q <= fifo_data;
								state_q <= S_POST;
							end
							`CMD_LOAD_NONCE: begin
								nonce_q <= fifo_data;
								state_q <= S_POST;
							end
							`CMD_ASSOC: begin
								st_q[319:192] <= st_q[319:192] ^ fifo_data;
							end
							`CMD_ENCRYPT: begin
								st_q[319:192] <= st_q[319:192] ^ fifo_data;
								dout_q <= st_q[319:192] ^ fifo_data;
							end
							`CMD_DECRYPT: begin
								st_q[319:192] <= fifo_data;
								dout_q <= st_q[319:192] ^ fifo_data;
							end
							default: begin
								tag_in_q <= fifo_data;
								tag_ok_q <= 1'b0;
								tag_fail_q <= 1'b0;
								st_q <= finalize_prep(st_q, key_q);
								rnd_q <= `RND_FIRST_A;
							end
						endcase
					end
				end
				// One round per cycle on the held state
				S_PERM: begin
					st_q <= round(st_q, rnd_q);
					rnd_q <= rnd_q + 4'h1;
					if (rnd_q == `RND_LAST) begin
						state_q <= S_POST;
					end
				end
				// Closing step of each operation
				default: begin
					case (op_q)
						`CMD_INIT: st_q[127:0] <= st_q[127:0] ^ key_q;
						`CMD_ASSOC: st_q[0] <= ~st_q[0];
						`CMD_LAST_ENC: dout_q <= tag_calc;
						`CMD_LAST_DEC: begin
							tag_ok_q <= (tag_calc == tag_in_q);
							tag_fail_q <= (tag_calc != tag_in_q);
						end
						default: dout_q <= dout_q;
					endcase
					status_q <= `ST_RESET;
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule // sponge_stream_cipher

// file: cipher_monitor.sv
// Port checker for the sponge cipher engine.
// Assumes a bind onto sponge_stream_cipher; one clock domain.
`timescale 1ns/1ps
`include "sponge_cipher_map.vh"
module cipher_monitor (
	// Clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// Command
	input wire cmd_valid,
	input wire [31:0] cmd_code,
	// Results
	input wire [127:0] dout_q,
	input wire [31:0] status_q,
	input wire busy_q,
	input wire done_q,
	input wire tag_ok_q,
	input wire tag_fail_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Command seen by an idle engine
	wire take = cmd_valid && !busy_q && !done_q;
	// Twelve-round init run
	sequence s_init_run;
		(status_q == 32'h0000_0001) ##13 done_q;
	endsequence
	// Eight-round block run after the wait for data
	sequence s_blk_run;
		(!done_q) [*8] ##[1:32] done_q;
	endsequence
	// ====================================================================
	// Assertions
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !busy_q && !done_q)
		else $error("outputs active after reset");
	a_idle_code: assert property (take && cmd_code < 32'h0000_0004 |=> (!busy_q && !done_q) [*3])
		else $error("idle code started work");
	a_take_busy: assert property (take && cmd_code inside {[4:11]} |=> busy_q)
		else $error("command not taken");
	a_init_len: assert property (take && cmd_code == `CMD_INIT |=> s_init_run)
		else $error("init timing wrong");
	a_enc_len: assert property ($rose(status_q[`ST_ENC_BIT]) |-> s_blk_run)
		else $error("encrypt timing wrong");
	a_tag_read: assert property (take && cmd_code == `CMD_READ_TAG |=> done_q)
		else $error("tag read late");
	a_status_one: assert property ($onehot0(status_q) && status_q[31:6] == 26'h0)
		else $error("status bits bad");
	a_done_idle: assert property (done_q |-> !busy_q && status_q == 32'h0000_0000 ##1 !done_q)
		else $error("done not clean");
	a_ad_silent: assert property (status_q[`ST_ASSOC_BIT] |=> $stable(dout_q))
		else $error("ad changed output");
	a_flags_excl: assert property (!(tag_ok_q && tag_fail_q))
		else $error("both tag flags");
endmodule // cipher_monitor

bind sponge_stream_cipher cipher_monitor cipher_monitor_inst (.clk_sys, .sys_rst, .cmd_valid,
	.cmd_code, .dout_q, .status_q, .busy_q, .done_q, .tag_ok_q, .tag_fail_q);

// file: cpu_model.sv
// Processor model: issues command strobes and offers blocks.
// Assumes the engine's strobe and valid/ready ports on one clock.
`timescale 1ns/1ps
module cpu_model (
	// Clock
	input wire clk_sys,
	// Command
	output logic cmd_valid,
	output logic [31:0] cmd_code,
	// Blocks
	output logic din_valid,
	input wire din_ready,
	output logic [127:0] din_data,
	// Answer
	input wire done_q
);
	int lat; // Edges from take to done, -1 if none
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 32'h0000_0000;
		din_valid = 1'b0;
		din_data = '1;
	end
	// One 16-byte block, held until accepted, then scrambled
	task push(input logic [127:0] b);
		@(posedge clk_sys);
		din_valid <= 1'b1;
		din_data <= b;
		do @(posedge clk_sys); while (din_ready !== 1'b1);
		din_valid <= 1'b0;
		din_data <= ~b;
	endtask
	// One-cycle command strobe
	task pulse(input logic [31:0] c);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
		cmd_code <= ~c;
	endtask
	// Command, then wait for done before anything else
	// Done may already stand just after the take edge (tag read)
	task run(input logic [31:0] c);
		pulse(c);
		lat = -1;
		for (int n = 0; n <= 40 && lat < 0; n++) begin
			if (n > 0) @(posedge clk_sys);
			#1;
			if (done_q === 1'b1) lat = n;
		end
	endtask
endmodule // cpu_model

// file: sponge_stream_authenticated_cipher_tb_top.sv
// Self-checking bench for the sponge cipher engine.
// Assumes cpu_model on the far side and the bound port checker.
`timescale 1ns/1ps
`include "sponge_cipher_map.vh"
module sponge_stream_authenticated_cipher_tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	wire cmd_valid, din_valid, din_ready, busy_q, done_q, tag_ok_q, tag_fail_q;
	wire [31:0] cmd_code, status_q;
	wire [127:0] din_data, dout_q;
	int miscompares = 0;
	int n_tests = 0;
	logic [127:0] ct [2]; // Ciphertext blocks
	logic [127:0] pt [2] = '{{4{32'h1111_2222}}, 128'h0000_0000_0000_0001};
	logic [127:0] tag;
	initial forever #4 clk_sys = ~clk_sys;
	sponge_stream_cipher sponge_stream_cipher_inst (.clk_sys, .sys_rst, .cmd_valid, .cmd_code,
		.din_valid, .din_ready, .din_data, .dout_q, .status_q, .busy_q, .done_q, .tag_ok_q,
		.tag_fail_q);
	cpu_model cpu_model_inst (.clk_sys, .cmd_valid, .cmd_code, .din_valid, .din_ready,
		.din_data, .done_q);
	// Compare and count
	task check(input logic [127:0] seen, input logic [127:0] want);
		n_tests++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task close_out;
		$display("%0d mismatches in %0d checks", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Command and check its latency
	task cmd(input logic [31:0] c, input int want);
		cpu_model_inst.run(c);
		check(128'(cpu_model_inst.lat), 128'(want));
	endtask
	task t_reset;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		check(128'({busy_q, done_q, status_q}), 128'h0);
		@(posedge clk_sys);
		#1;
		check(128'(din_ready), 128'h1);
	endtask
	task t_idle;
		for (int c = 0; c < 4; c++) cmd(32'(c), -1);
	endtask
	// Key, nonce, init with a stray strobe, zero AD
	task t_open;
		cpu_model_inst.push({4{32'h0F1E_2D3C}});
		cmd(`CMD_LOAD_KEY, 2);
		cpu_model_inst.push(128'h0);
		cmd(`CMD_LOAD_NONCE, 2);
		fork
			cmd(`CMD_INIT, 13);
			begin repeat (4) @(posedge clk_sys); cpu_model_inst.pulse(`CMD_ENCRYPT); end
		join
		cpu_model_inst.push(128'h0);
		tag = dout_q;
		cmd(`CMD_ASSOC, 10);
		check(dout_q, tag);
	endtask
	task t_wrap;
		t_open;
		for (int i = 0; i < 2; i++) begin
			cpu_model_inst.push(pt[i]);
			cmd(`CMD_ENCRYPT, 10);
			ct[i] = dout_q;
		end
		cmd(`CMD_LAST_ENC, 13);
		tag = dout_q;
		cmd(`CMD_READ_TAG, 0);
		check(dout_q, tag);
	endtask
	task t_unwrap(input logic bad);
		t_open;
		for (int i = 0; i < 2; i++) begin
			cpu_model_inst.push(ct[i]);
			cmd(`CMD_DECRYPT, 10);
			check(dout_q, pt[i]);
		end
		cpu_model_inst.push(tag ^ 128'(bad));
		cmd(`CMD_LAST_DEC, 14);
		check(128'({tag_ok_q, tag_fail_q}), bad ? 128'h1 : 128'h2);
	endtask
	// Fill the FIFO until it refuses, then drain it
	task t_fifo;
		for (int i = 0; i < 4; i++) cpu_model_inst.push(pt[i % 2]);
		@(posedge clk_sys);
		#1;
		check(128'(din_ready), 128'h0);
		for (int i = 0; i < 4; i++) cmd(`CMD_ASSOC, 10);
		check(128'(din_ready), 128'h1);
	endtask
	// Command message: padded response nonce, typed associated data, tag only
	task t_cmd_msg;
		cpu_model_inst.push({4{32'h0F1E_2D3C}});
		cmd(`CMD_LOAD_KEY, 2);
		cpu_model_inst.push({64'h5A5A_C3C3_0F0F_9696, 64'h0});
		cmd(`CMD_LOAD_NONCE, 2);
		cmd(`CMD_INIT, 13);
		cpu_model_inst.push({8'h01, 120'h0});
		cmd(`CMD_ASSOC, 10);
		cmd(`CMD_LAST_ENC, 13);
	endtask
	initial begin
		t_reset;
		t_idle;
		t_wrap;
		t_unwrap(1'b0);
		t_unwrap(1'b1);
		t_fifo;
		t_cmd_msg;
		close_out;
	end
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		close_out;
	end
endmodule // sponge_stream_authenticated_cipher_tb_top
